/* File: logic/rsl_pkg.sv */
/*
 * rsl_pkg: constants and carrier types for the reset source logic.
 * Assumes a single 250 MHz system clock and an APB register port.
 */
package rsl_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS    = 4000;
	localparam int unsigned MCD_TIMEOUT_US   = 100;
	// longest time rounds down
	localparam int unsigned MCD_TIMEOUT_CYC  = (MCD_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
	localparam int unsigned WDT_DIV          = 12;
	localparam int unsigned WDT_LIMIT_DFLT   = 16'hFFFF;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h00;
	localparam logic [7:0] ADDR_WDT_CTRL     = 8'h04;
	localparam logic [7:0] ADDR_WDT_KICK     = 8'h08;
	localparam logic [7:0] ADDR_WDT_LIMIT    = 8'h0C;
	localparam logic [7:0] ADDR_FLASH_CFG    = 8'h10;

	// ----------------------------------------------------------------
	// reset cause register fields
	// ----------------------------------------------------------------
	localparam int unsigned BIT_PIN          = 0;
	localparam int unsigned BIT_MCD          = 2;
	localparam int unsigned BIT_WDT          = 3;
	localparam int unsigned BIT_CMP          = 5;
	localparam int unsigned BIT_FERR         = 6;

	// flash config fields
	localparam int unsigned BIT_FWE          = 0;

	localparam logic [15:0] LOCK_ADDR_RST    = 16'h1DFF;

	typedef enum logic [2:0] {
		RSL_CAUSE_NONE,
		RSL_CAUSE_PIN,
		RSL_CAUSE_MCD,
		RSL_CAUSE_WDT,
		RSL_CAUSE_CMP,
		RSL_CAUSE_FERR
	} rsl_cause_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rsl_apb_req_t;

	typedef struct packed {
		logic        wr_valid;
		logic [15:0] wr_addr;
		logic        rd_valid;
		logic [15:0] rd_addr;
		logic        fetch_valid;
		logic [15:0] fetch_addr;
		logic        sec_block;
		logic        erase_valid;
	} rsl_flash_t;

endpackage

/* File: logic/rsl_mcd.sv */
/*
 * rsl_mcd: missing clock timeout, held high while the clock stays stuck. Counts cycles of a reference tick
 * domain-free: the watched clock is sampled as a level input.
 * Assumes clk_level is sampled on the fast reference clock clk.
 */
module rsl_mcd #(
	parameter int unsigned TIMEOUT_CYC = rsl_pkg::MCD_TIMEOUT_CYC
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic enable,
	input  wire logic clk_level,
	output logic      timeout
);
	typedef struct packed {
		logic [23:0] cnt;
		logic        last;
		logic        fire;
	} rsl_mcd_st_t;

	rsl_mcd_st_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.last = clk_level;
		s_d.fire = 1'b0;
		// any edge of the watched clock restarts the timeout count
		if (!enable || clk_level != s_q.last) begin
			s_d.cnt = 24'h000000;
		end else if (s_q.cnt >= 24'(TIMEOUT_CYC)) begin
			s_d.fire = 1'b1; // RQ3
		end else begin
			s_d.cnt = s_q.cnt + 24'h000001;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign timeout = s_q.fire;
endmodule // rsl_mcd

/* File: logic/rsl_wdt.sv */
/*
 * rsl_wdt: watchdog counter ticking at system clock / 12.
 * Assumes software kicks it through the register block.
 */
module rsl_wdt #(
	parameter int unsigned DIV = rsl_pkg::WDT_DIV
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        sys_rst,
	input  wire logic        enable,
	input  wire logic        kick,
	input  wire logic [15:0] limit,
	output logic             expire
);
	typedef struct packed {
		logic [3:0]  pre;
		logic [15:0] cnt;
		logic        fire;
	} rsl_wdt_st_t;

	rsl_wdt_st_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.fire = 1'b0;
		if (sys_rst || !enable || kick) begin
			s_d.pre = 4'h0;
			s_d.cnt = 16'h0000;
		end else if (s_q.pre == 4'(DIV - 1)) begin
			s_d.pre = 4'h0; // RQ10
			if (s_q.cnt >= limit) begin
				s_d.fire = 1'b1; // RQ11
				s_d.cnt  = 16'h0000;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end else begin
			s_d.pre = s_q.pre + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expire = s_q.fire;
endmodule // rsl_wdt

/* File: logic/rsl_top.sv */
/*
 * rsl_top: reset source logic. Merges pin, missing clock, comparator,
 * watchdog and flash error causes into one system reset, records the
 * cause, and exposes an APB register port.
 * Assumes all inputs synchronous to clk; nrst is the external pin.
 */
// The implementer's own choices: the APB interface to the registers and the register addresses.
// Behaviour
// RQ1 - external active-low reset pin holds the device in reset
// RQ2 - leaving a pin reset sets pin flag bit 0
// RQ3 - system clock stuck over 100 us triggers a reset
// RQ4 - bit 2 reads 1 only after missing-clock reset
// RQ5 - writing bit 2 enables or disables the missing-clock detector
// RQ6 - writing 1 to bit 5 makes the comparator a reset source
// RQ7 - enabled comparator resets while noninverting input below inverting
// RQ8 - bit 5 reads 1 only after comparator reset
// RQ9 - software settles comparator before enabling it as reset source
// RQ10 - after any reset watchdog runs enabled on clock divided by 12
// RQ11 - watchdog expiry resets and sets watchdog flag
// RQ12 - internal resets never drive the external reset pin
// RQ13 - flash write above lock byte with write enable causes reset
// RQ14 - code read above lock byte causes reset
// RQ15 - branch above lock byte causes reset
// RQ16 - flash access blocked by security causes reset
// RQ17 - flash write or erase without high supply monitor causes reset
// RQ18 - flash error reset sets flag bit 6
// RQ19 - all causes merge into one reset, released when all gone
// RQ20 - only the latest reset cause flag reads 1
module rsl_top #(
	parameter int unsigned MCD_CYC = rsl_pkg::MCD_TIMEOUT_CYC
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               system_clock_level,
	input  wire logic               comparator_out,
	input  wire logic               supply_monitor_on,
	input  wire logic               supply_monitor_high,
	input  wire rsl_pkg::rsl_flash_t flash,
	output logic                    sys_rst
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        pin_seen;
		logic        pin_reset_flag;
		logic        missing_clock_flag;
		logic        watchdog_reset_flag;
		logic        comparator_reset_flag;
		logic        flash_error_flag;
		logic        mcd_en;
		logic        cmp_en;
		logic        wdt_en;
		logic        wdt_kick;
		logic [15:0] wdt_limit;
		logic        flash_write_enable;
		logic [15:0] lock_addr;
		logic        rst_hold;
		logic        sys_rst;
		logic        mcd_latch;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rsl_top_st_t;

	rsl_top_st_t s_q, s_d;

	logic mcd_timeout;
	logic wdt_expire;
	logic flash_err;
	logic cmp_rst;
	logic any_cause;
	logic wr_acc;
	logic rd_acc;

	// ----------------------------------------------------------------
	// cause detectors
	// ----------------------------------------------------------------
	rsl_mcd #(
		.TIMEOUT_CYC (MCD_CYC)
	) u_mcd (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (s_q.mcd_en),
		.clk_level (system_clock_level),
		.timeout   (mcd_timeout)
	);

	rsl_wdt #(
		.DIV (rsl_pkg::WDT_DIV)
	) u_wdt (
		.clk     (clk),
		.nrst    (nrst),
		.sys_rst (s_q.sys_rst),
		.enable  (s_q.wdt_en),
		.kick    (s_q.wdt_kick),
		.limit   (s_q.wdt_limit),
		.expire  (wdt_expire)
	);

	// comparator output high means noninverting input above inverting
	assign cmp_rst = s_q.cmp_en && !comparator_out; // RQ7

	assign flash_err =
		(flash.wr_valid && s_q.flash_write_enable &&
			flash.wr_addr > s_q.lock_addr) ||                   // RQ13
		(flash.rd_valid && flash.rd_addr > s_q.lock_addr) ||     // RQ14
		(flash.fetch_valid && flash.fetch_addr > s_q.lock_addr) || // RQ15
		flash.sec_block ||                                     // RQ16
		((flash.wr_valid && s_q.flash_write_enable || flash.erase_valid) &&
			!(supply_monitor_on && supply_monitor_high));      // RQ17

	assign any_cause = mcd_timeout || wdt_expire || cmp_rst || flash_err;
	assign wr_acc    = psel && penable && pwrite;
	assign rd_acc    = psel && !penable && !pwrite;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.wdt_kick = 1'b0;
		s_d.pready   = 1'b0;
		s_d.pslverr  = 1'b0;
		// sticky one-shot causes are held one cycle so the reset has width
		s_d.rst_hold = any_cause; // RQ19
		s_d.sys_rst  = any_cause || s_q.rst_hold; // RQ19
		// first cycle after the pin is released records a pin reset
		if (!s_q.pin_seen) begin
			s_d.pin_seen       = 1'b1;
			s_d.pin_reset_flag = 1'b1; // RQ2
		end
		if (any_cause && !s_q.sys_rst) begin
			// RQ20: flags rewritten at the moment a reset is taken
			s_d.pin_reset_flag        = 1'b0;
			s_d.missing_clock_flag    = mcd_timeout; // RQ4
			s_d.watchdog_reset_flag   = wdt_expire && !mcd_timeout; // RQ11
			s_d.comparator_reset_flag = cmp_rst && !mcd_timeout && !wdt_expire; // RQ8
			s_d.flash_error_flag      = flash_err && !mcd_timeout && !wdt_expire
				&& !cmp_rst; // RQ18
			s_d.wdt_en    = 1'b1; // RQ10
			s_d.wdt_limit = 16'(rsl_pkg::WDT_LIMIT_DFLT);
		end
		// apb: answer in the access phase, one cycle after setup
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h00000000;
			unique case (paddr)
				rsl_pkg::ADDR_RESET_CAUSE: begin
					s_d.prdata[rsl_pkg::BIT_PIN]  = s_q.pin_reset_flag;
					s_d.prdata[rsl_pkg::BIT_MCD]  = s_q.missing_clock_flag;
					s_d.prdata[rsl_pkg::BIT_WDT]  = s_q.watchdog_reset_flag;
					s_d.prdata[rsl_pkg::BIT_CMP]  = s_q.comparator_reset_flag;
					s_d.prdata[rsl_pkg::BIT_FERR] = s_q.flash_error_flag;
				end
				rsl_pkg::ADDR_WDT_CTRL:  s_d.prdata[0] = s_q.wdt_en;
				rsl_pkg::ADDR_WDT_KICK:  s_d.prdata = 32'h00000000;
				rsl_pkg::ADDR_WDT_LIMIT: s_d.prdata[15:0] = s_q.wdt_limit;
				rsl_pkg::ADDR_FLASH_CFG: begin
					s_d.prdata[rsl_pkg::BIT_FWE] = s_q.flash_write_enable;
					s_d.prdata[31:16]            = s_q.lock_addr;
				end
				default: s_d.pslverr = 1'b1;
			endcase
		end
		if (wr_acc && s_q.pready) begin
			unique case (paddr)
				rsl_pkg::ADDR_RESET_CAUSE: begin
					s_d.mcd_en = pwdata[rsl_pkg::BIT_MCD]; // RQ5
					s_d.cmp_en = pwdata[rsl_pkg::BIT_CMP]; // RQ6
				end
				rsl_pkg::ADDR_WDT_CTRL:  s_d.wdt_en = pwdata[0];
				rsl_pkg::ADDR_WDT_KICK:  s_d.wdt_kick = 1'b1;
				rsl_pkg::ADDR_WDT_LIMIT: s_d.wdt_limit = pwdata[15:0];
				rsl_pkg::ADDR_FLASH_CFG: begin
					s_d.flash_write_enable = pwdata[rsl_pkg::BIT_FWE];
					s_d.lock_addr          = pwdata[31:16];
				end
				default: ;
			endcase
		end
		// internal resets clear the comparator and flash write enables, force the watchdog on and keep the missing-clock enable
		if (s_q.sys_rst) begin
			s_d.cmp_en             = 1'b0;
			s_d.flash_write_enable = 1'b0;
			s_d.wdt_en             = 1'b1; // RQ10
		end
		if (rd_acc) begin
			s_d.pready = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers; pin reset forces everything (RQ1), and nothing here
	// drives the pin back (RQ12)
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q           <= '0; // RQ1
			s_q.sys_rst   <= 1'b1; // RQ1
			s_q.wdt_en    <= 1'b1; // RQ10
			s_q.wdt_limit <= 16'(rsl_pkg::WDT_LIMIT_DFLT);
			s_q.lock_addr <= rsl_pkg::LOCK_ADDR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.prdata;
	assign pready  = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign sys_rst = s_q.sys_rst; // RQ12
endmodule // rsl_top

/* File: bench/rsl_far.sv */
/*
 * rsl_far: outside reset circuit and comparator front end.
 * Assumes the bench commands both levels just after clock edges.
 */
module rsl_far (
	input  wire logic clk,
	input  wire logic hold,
	input  wire logic below,
	output logic      nrst,
	output logic      comparator_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin pulled low only while the outside circuit asserts it
	always @(posedge clk) nrst <= !hold;
	// low while the noninverting input sits below; registered, so it follows below one clock late
	always @(posedge clk) comparator_out <= !below;
endmodule // rsl_far

/* File: bench/rsl_sva.sv */
/*
 * rsl_sva: reset timing properties of rsl_top at its ports.
 * Assumes the flash lock address stays at its reset value.
 */
module rsl_sva #(
	parameter int unsigned MCD_CYC = rsl_pkg::MCD_TIMEOUT_CYC
) (
	input wire logic                clk,
	input wire logic                nrst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic                pready,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                system_clock_level,
	input wire logic                comparator_out,
	input wire logic                supply_monitor_on,
	input wire logic                supply_monitor_high,
	input wire rsl_pkg::rsl_flash_t flash,
	input wire logic                sys_rst
);
	// ----
	// enables mirrored from register writes
	// ----
	logic        cmp_q, fwe_q, mcd_q, lvl_q;
	logic [15:0] cnt_q;
	wire         wr = psel && penable && pready && pwrite;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmp_q <= 1'h0;
			fwe_q <= 1'h0;
			mcd_q <= 1'h0;
			lvl_q <= 1'h0;
			cnt_q <= 16'h0;
		end else begin
			lvl_q <= system_clock_level;
			// any edge, a reset or a disabled detector restarts the count
			cnt_q <= (lvl_q != system_clock_level || !mcd_q || sys_rst) ? 16'h0 : cnt_q + 16'h1;
			if (wr && paddr == 8'h00) begin
				cmp_q <= pwdata[5];
				mcd_q <= pwdata[2];
			end else if (sys_rst) begin
				cmp_q <= 1'h0;
			end
			if (wr && paddr == 8'h10) begin
				fwe_q <= pwdata[0];
			end else if (sys_rst) begin
				fwe_q <= 1'h0;
			end
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	property p_pin;
		$rose(nrst) |-> $past(sys_rst);
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset not held");
	property p_wid;
		$rose(sys_rst) |-> sys_rst [*2];
	endproperty
	a_wid: assert property (p_wid) else $error("reset too short");
	property p_mcd;
		mcd_q && cnt_q >= MCD_CYC + 4 |-> sys_rst;
	endproperty
	a_mcd: assert property (p_mcd) else $error("stuck clock missed");
	property p_cmp;
		cmp_q && !comparator_out && !sys_rst |=> sys_rst;
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator missed");
	property p_wr;
		fwe_q && flash.wr_valid && flash.wr_addr > rsl_pkg::LOCK_ADDR_RST && !sys_rst |=> sys_rst;
	endproperty
	a_wr: assert property (p_wr) else $error("high write missed");
	property p_rd;
		flash.rd_valid && flash.rd_addr > rsl_pkg::LOCK_ADDR_RST && !sys_rst |=> sys_rst;
	endproperty
	a_rd: assert property (p_rd) else $error("high read missed");
	property p_fet;
		flash.fetch_valid && flash.fetch_addr > rsl_pkg::LOCK_ADDR_RST && !sys_rst |=> sys_rst;
	endproperty
	a_fet: assert property (p_fet) else $error("high fetch missed");
	property p_sec;
		flash.sec_block && !sys_rst |=> sys_rst;
	endproperty
	a_sec: assert property (p_sec) else $error("blocked access missed");
	property p_pwr;
		flash.erase_valid && !(supply_monitor_on && supply_monitor_high) && !sys_rst |=> sys_rst;
	endproperty
	a_pwr: assert property (p_pwr) else $error("low supply erase missed");
	c_rst: cover property ($rose(sys_rst));
	c_mcd: cover property (mcd_q && cnt_q > 16'h5);
	c_cmp: cover property (cmp_q && !comparator_out);
endmodule // rsl_sva

bind rsl_top rsl_sva #(.MCD_CYC(MCD_CYC)) u_sva (.clk, .nrst, .psel, .penable, .pwrite,
	.pready, .paddr, .pwdata, .system_clock_level, .comparator_out, .supply_monitor_on,
	.supply_monitor_high, .flash, .sys_rst);

/* File: bench/rsl_tb_top.sv */
/*
 * rsl_tb_top: self-checking bench for the reset source logic.
 * Assumes rsl_far on pin and comparator and a 250 MHz clock.
 */
module rsl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk = 1'h0;
	logic                psel, penable, pwrite, pready, pslverr, nrst, sys_rst;
	logic                hold, below, run, cmp, s_on, s_hi;
	logic                lvl = 1'h0;
	logic                rst_d = 1'h0;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata;
	logic [64:0]         exp_q[$];
	logic [64:0]         e;
	rsl_pkg::rsl_flash_t flash;
	int                  err_count = 0;
	int                  checks_done = 0;
	int                  rises = 0;
	int                  seed = 43;
	int                  n;
	always #2 clk = !clk;
	rsl_far far_u (.clk, .hold, .below, .nrst, .comparator_out(cmp));
	rsl_top #(.MCD_CYC(20)) dut_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .system_clock_level(lvl), .comparator_out(cmp),
		.supply_monitor_on(s_on), .supply_monitor_high(s_hi), .flash, .sys_rst);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] want, input string m);
		checks_done++;
		if (got !== want) begin
			err_count++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, m, got, want);
		end
	endtask
	task automatic fail(input string m);
		err_count++;
		$display("mismatch at %0t: %s timed out", $time, m);
		finish_test();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		if (pready !== 1'h1) fail("apb");
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic er);
		exp_q.push_back({er, 32'h6D, v});
		xfer(1'h0, a, 32'h0);
	endtask
	task automatic wt(input logic v, input int lim);
		n = 0;
		while (sys_rst !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (sys_rst !== v) fail("reset wait");
	endtask
	// ----
	// result monitor
	// ----
	always @(posedge clk) begin
		rst_d <= sys_rst;
		if (sys_rst === 1'h1 && rst_d === 1'h0) rises++;
		if (psel && penable && pready === 1'h1 && !pwrite) begin
			e = exp_q.pop_front();
			chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & {32{!e[64]}}}, "read");
		end
	end
	always @(posedge clk) if (run) lvl <= !lvl;
	// ----
	// main sequence
	// ----
	initial begin
		rsl_pkg::rsl_flash_t f;
		int k0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{hold, below, run, s_on, s_hi} = 5'h17;
		flash = '0;
		repeat (5) @(posedge clk);
		chk(33'(sys_rst), 33'h1, "pin hold");
		repeat (5) @(posedge clk);
		hold <= 1'h0;
		wt(1'h0, 10);
		rd(8'h00, 32'h1, 1'h0);
		rd(8'hFC, 32'h0, 1'h1);
		$display("pin test done");
		xfer(1'h1, 8'h00, 32'h4);
		run <= 1'h0;
		wt(1'h1, 40);
		chk(33'(n > 20 && n < 30), 33'h1, "early");
		run <= 1'h1;
		wt(1'h0, 20);
		rd(8'h00, 32'h4, 1'h0);
		xfer(1'h1, 8'h00, 32'h0);
		k0 = rises;
		run <= 1'h0;
		repeat (40) @(posedge clk);
		chk(33'(rises), 33'(k0), "detector off");
		run <= 1'h1;
		$display("clock test done");
		xfer(1'h1, 8'h00, 32'h20);
		below <= 1'h1;
		wt(1'h1, 10);
		below <= 1'h0;
		wt(1'h0, 20);
		rd(8'h00, 32'h20, 1'h0);
		$display("comparator test done");
		xfer(1'h1, 8'h0C, 32'h3);
		k0 = rises;
		// kicks span longer than one full expiry, so a lost kick would show
		repeat (20) xfer(1'h1, 8'h08, 32'h0);
		chk(33'(rises), 33'(k0), "kicked");
		wt(1'h1, 100);
		chk(33'(n > 23 && n < 53), 33'h1, "divide");
		wt(1'h0, 20);
		rd(8'h00, 32'h8, 1'h0);
		xfer(1'h1, 8'h0C, 32'hFFFF);
		$display("watchdog test done");
		for (int k = 0; k < 5; k++) begin
			xfer(1'h1, 8'h10, 32'h1DFF0001);
			f = '0;
			f.wr_addr = 16'h1E00 + 16'($random(seed) & 32'hFFF);
			f.rd_addr = f.wr_addr;
			f.fetch_addr = f.wr_addr;
			f.wr_valid = (k == 0);
			f.rd_valid = (k == 1);
			f.fetch_valid = (k == 2);
			f.sec_block = (k == 3);
			f.erase_valid = (k == 4);
			flash <= f;
			s_on <= (k == 4) ? 1'($random(seed)) : 1'h1;
			s_hi <= (k != 4);
			@(posedge clk);
			flash <= '0;
			s_on <= 1'h1;
			s_hi <= 1'h1;
			wt(1'h1, 10);
			wt(1'h0, 20);
			rd(8'h00, 32'h40, 1'h0);
		end
		$display("flash test done");
		// pin reset in mid-run must clear the flash flag and set the pin flag
		hold <= 1'h1;
		repeat (4) @(posedge clk);
		chk(33'(sys_rst), 33'h1, "pin hold again");
		hold <= 1'h0;
		wt(1'h0, 10);
		rd(8'h00, 32'h1, 1'h0);
		$display("second reset test done");
		finish_test();
	end
endmodule // rsl_tb_top
